/* File: shared/btirq_pkg.sv */
// Package: register map, field positions and bus codes for the transfer interrupt block
package btirq_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_SRC_EN = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STAT_LO = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STAT_HI = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_EN_LO = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_EN_HI = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_HOST_CTRL = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_SRC_FLAG = 8'h18;
   // Field widths
   localparam int SRC_W = 3;
   localparam int LO_W = 5;
   localparam int HI_W = 1;
   // Source enable / source flag positions
   localparam int BIT_STS_RX_END = 2;
   localparam int BIT_CTL_TX_END = 1;
   localparam int BIT_XFER_START = 0;
   // Low status register flag positions
   localparam int BIT_FIFO_RD_REQ = 4;
   localparam int BIT_HOST_RD = 3;
   localparam int BIT_HOST_WR = 2;
   localparam int BIT_WR_START = 1;
   localparam int BIT_RD_END = 0;
   // Reserved fields
   localparam int RSV_LO_MSB = 7;
   localparam int RSV_LO_LSB = 5;
   localparam int RSV_LO_W = RSV_LO_MSB - RSV_LO_LSB + 1;
   localparam int RSV_HI = 7;
   // High status register flag and global enable positions
   localparam int BIT_SLV_RST = 6;
   localparam int BIT_GLOBAL_EN = 0;
   // Reset values
   localparam logic [7:0] RST_VAL = 8'h00;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : btirq_pkg

/* File: shared/btirq_flag_if.sv */
// Interface: control path between register front end and one flag bank
`timescale 1ns/10ps
`default_nettype none
interface btirq_flag_if #(parameter int W = 1);
   logic [W-1:0] set; // Hardware event pulses
   logic rd; // Register read strobe
   logic wr; // Register write strobe
   logic [W-1:0] wdata; // Write data for the flags
   logic [W-1:0] flags; // Current flag values
   modport bank (input set, input rd, input wr, input wdata, output flags);
   modport ctl (output set, output rd, output wr, output wdata, input flags);
endinterface : btirq_flag_if
`default_nettype wire

/* File: rtl/btirq_flag_bank.sv */
// Module: bank of sticky flags cleared by read-one-then-write-zero
`timescale 1ns/10ps
`default_nettype none
module btirq_flag_bank
   import btirq_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   btirq_flag_if.bank f
);

   logic [W-1:0] flag_reg; // Sticky flags
   logic [W-1:0] armed_reg; // Flag was read as one
   logic [W-1:0] clr; // Clear request this cycle
   logic [W-1:0] flag_next;
   logic [W-1:0] armed_next;

   // Only an armed flag written with zero clears; a one leaves it
   always_comb begin
      clr = f.wr ? (armed_reg & ~f.wdata) : '0;
      // Event wins over a clear in the same cycle
      flag_next = f.set | (flag_reg & ~clr);
      // A fresh read of one arms; a clear or a drop disarms
      armed_next = flag_next & ~clr & (armed_reg | (f.rd ? flag_reg : '0));
   end

   // Flag state
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // Arming state
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         armed_reg <= '0;
      end else begin
         armed_reg <= armed_next;
      end
   end

   assign f.flags = flag_reg;
endmodule : btirq_flag_bank
`default_nettype wire

/* File: rtl/btirq_top.sv */
// Module: transfer slave interrupt flags with AXI4-Lite register access
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Status-code receive-end enable, bit 2, reset 0
// - Control-code transmit-end enable, bit 1, reset 0
// - Transfer-start enable, bit 0, reset 0
// - Low status bits 7..5 reserved, writable, reset 0
// - Host write while FIFO full sets bit 4
// - Flag interrupts only when set and enabled
// - Host byte read sets bit 3
// - Host byte write sets bit 2
// - First valid host write sets bit 1
// - Host finishing all reads sets bit 0
// - Clear by writing zero after reading one
// - Rising reset request edge sets high bit 6
// - Global enable bit gates the shared interrupt
module btirq_top
   import btirq_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   // AXI4-Lite write response
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   // AXI4-Lite read data
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // Host-side events, one-cycle pulses from the bus decoder, plus the FIFO full level
   input wire logic host_byte_read_i,
   input wire logic host_byte_write_i,
   input wire logic host_write_start_i,
   input wire logic host_read_end_i,
   input wire logic fifo_full_i,
   input wire logic status_code_rx_end_i,
   input wire logic control_code_tx_end_i,
   input wire logic transfer_start_i,
   // Host-written reset request level
   input wire logic slave_hw_reset_request_i,
   // Shared interrupt to the local processor
   output logic shared_slave_interrupt_o
);

   // Address decode shared by both channels
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_SRC_EN, OFF_STAT_LO, OFF_STAT_HI, OFF_EN_LO,
         OFF_EN_HI, OFF_HOST_CTRL, OFF_SRC_FLAG: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction : addr_mapped

   // Flag bank carriers
   btirq_flag_if #(.W(SRC_W)) src_if ();
   btirq_flag_if #(.W(LO_W)) lo_if ();
   btirq_flag_if #(.W(HI_W)) hi_if ();

   // Software-owned registers
   logic [SRC_W-1:0] src_en_reg; // Source enables, bits 2..0
   logic [LO_W-1:0] en_lo_reg; // Enables for low status flags
   logic hi_en_reg; // Enable for slave reset flag
   logic global_en_reg; // Global interrupt enable
   logic [RSV_LO_W-1:0] rsv_lo_reg; // Reserved low status bits
   logic rsv_hi_reg; // Reserved high status bit

   // Write channel holding state
   logic aw_full_reg; // Address captured
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_full_reg; // Data captured
   logic [7:0] w_byte_reg; // Byte lane 0 only
   logic w_lane_reg; // Lane 0 strobe
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   // Read channel state
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // Reset request edge detector
   logic rst_req_d_reg;

   // Handshake terms
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic wr_en; // Write lands in a register
   logic ar_take;
   logic [31:0] rd_mux;

   // Address may be taken while no response is pending
   assign awready_o = !aw_full_reg && !bvalid_reg;
   assign wready_o = !w_full_reg && !bvalid_reg;
   assign arready_o = !rvalid_reg;
   assign aw_take = awvalid_i && awready_o;
   assign w_take = wvalid_i && wready_o;
   // Commit once both halves are held
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   // Only lane 0 carries register bits; other lanes are ignored
   assign wr_en = wr_fire && w_lane_reg && addr_mapped(aw_addr_reg);
   assign ar_take = arvalid_i && arready_o;

   // Capture write address
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (aw_take) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= awaddr_i;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   // Capture write data
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         w_full_reg <= 1'b0;
         w_byte_reg <= RST_VAL;
         w_lane_reg <= 1'b0;
      end else if (w_take) begin
         w_full_reg <= 1'b1;
         w_byte_reg <= wdata_i[7:0];
         w_lane_reg <= wstrb_i[0];
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer with an error
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign bvalid_o = bvalid_reg;
   assign bresp_o = bresp_reg;

   // Source enable register
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         src_en_reg <= RST_VAL[SRC_W-1:0];
      end else if (wr_en && aw_addr_reg == OFF_SRC_EN) begin
         src_en_reg[BIT_STS_RX_END] <= w_byte_reg[BIT_STS_RX_END];
         src_en_reg[BIT_CTL_TX_END] <= w_byte_reg[BIT_CTL_TX_END];
         src_en_reg[BIT_XFER_START] <= w_byte_reg[BIT_XFER_START];
      end
   end

   // Low status enables
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         en_lo_reg <= RST_VAL[LO_W-1:0];
      end else if (wr_en && aw_addr_reg == OFF_EN_LO) begin
         en_lo_reg <= w_byte_reg[LO_W-1:0];
      end
   end

   // High status enable
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hi_en_reg <= 1'b0;
      end else if (wr_en && aw_addr_reg == OFF_EN_HI) begin
         hi_en_reg <= w_byte_reg[BIT_SLV_RST];
      end
   end

   // Global enable in host interface control
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         global_en_reg <= 1'b0;
      end else if (wr_en && aw_addr_reg == OFF_HOST_CTRL) begin
         global_en_reg <= w_byte_reg[BIT_GLOBAL_EN];
      end
   end

   // Reserved status bits are plain storage; nothing reads them internally
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rsv_lo_reg <= RST_VAL[RSV_LO_W-1:0];
      end else if (wr_en && aw_addr_reg == OFF_STAT_LO) begin
         rsv_lo_reg <= w_byte_reg[RSV_LO_MSB:RSV_LO_LSB];
      end
   end

   // Reserved high status bit
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rsv_hi_reg <= 1'b0;
      end else if (wr_en && aw_addr_reg == OFF_STAT_HI) begin
         rsv_hi_reg <= w_byte_reg[RSV_HI];
      end
   end

   // Previous level of the reset request, for edge detection
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rst_req_d_reg <= 1'b0;
      end else begin
         rst_req_d_reg <= slave_hw_reset_request_i;
      end
   end

   // Event sources into the source flag bank
   assign src_if.set[BIT_STS_RX_END] = status_code_rx_end_i;
   assign src_if.set[BIT_CTL_TX_END] = control_code_tx_end_i;
   assign src_if.set[BIT_XFER_START] = transfer_start_i;

   // A write refused by a full FIFO asks software to drain it
   assign lo_if.set[BIT_FIFO_RD_REQ] = host_byte_write_i && fifo_full_i;
   assign lo_if.set[BIT_HOST_RD] = host_byte_read_i;
   assign lo_if.set[BIT_HOST_WR] = host_byte_write_i;
   assign lo_if.set[BIT_WR_START] = host_write_start_i;
   assign lo_if.set[BIT_RD_END] = host_read_end_i;

   // Only the rising edge counts; a held request sets once
   assign hi_if.set[0] = slave_hw_reset_request_i && !rst_req_d_reg;

   // Read strobes arm the flags for a later clear
   assign src_if.rd = ar_take && araddr_i == OFF_SRC_FLAG;
   assign lo_if.rd = ar_take && araddr_i == OFF_STAT_LO;
   assign hi_if.rd = ar_take && araddr_i == OFF_STAT_HI;

   // Write strobes request clears; the bank decides if armed
   assign src_if.wr = wr_en && aw_addr_reg == OFF_SRC_FLAG;
   assign lo_if.wr = wr_en && aw_addr_reg == OFF_STAT_LO;
   assign hi_if.wr = wr_en && aw_addr_reg == OFF_STAT_HI;
   assign src_if.wdata = w_byte_reg[SRC_W-1:0];
   // FIFO request clear relies on software draining first
   assign lo_if.wdata = w_byte_reg[LO_W-1:0];
   assign hi_if.wdata = w_byte_reg[BIT_SLV_RST:BIT_SLV_RST];

   // Flag banks
   btirq_flag_bank #(.W(SRC_W)) u_src_bank (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .f(src_if.bank)
   );

   btirq_flag_bank #(.W(LO_W)) u_lo_bank (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .f(lo_if.bank)
   );

   btirq_flag_bank #(.W(HI_W)) u_hi_bank (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .f(hi_if.bank)
   );

   // Read data selection; unmapped reads return zero
   always_comb begin
      rd_mux = '0;
      case (araddr_i)
         OFF_SRC_EN: begin
            rd_mux[SRC_W-1:0] = src_en_reg;
         end
         OFF_STAT_LO: begin
            rd_mux[LO_W-1:0] = lo_if.flags;
            rd_mux[RSV_LO_MSB:RSV_LO_LSB] = rsv_lo_reg;
         end
         OFF_STAT_HI: begin
            rd_mux[BIT_SLV_RST] = hi_if.flags[0];
            rd_mux[RSV_HI] = rsv_hi_reg;
         end
         OFF_EN_LO: begin
            rd_mux[LO_W-1:0] = en_lo_reg;
         end
         OFF_EN_HI: begin
            rd_mux[BIT_SLV_RST] = hi_en_reg;
         end
         OFF_HOST_CTRL: begin
            rd_mux[BIT_GLOBAL_EN] = global_en_reg;
         end
         OFF_SRC_FLAG: begin
            rd_mux[SRC_W-1:0] = src_if.flags;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // Read response, one cycle after the address is taken
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= addr_mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign rvalid_o = rvalid_reg;
   assign rdata_o = rdata_reg;
   assign rresp_o = rresp_reg;

   // Combinational so an enable change acts in the same cycle
   always_comb begin
      shared_slave_interrupt_o = global_en_reg && (
         |(src_if.flags & src_en_reg) ||
         |(lo_if.flags & en_lo_reg) ||
         (hi_if.flags[0] && hi_en_reg));
   end

endmodule : btirq_top
`default_nettype wire

/* File: dv/btirq_host_model.sv */
// Host model: drives buffer and control events toward the interrupt block
`timescale 1ns/10ps
`default_nettype none
module btirq_host_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic go_i, // Start one host action
   input wire logic [3:0] op_i, // Action code
   output logic [7:0] ev_o, // One-hot event pulses
   output logic fifo_full_o, // FIFO full level
   output logic rst_req_o // Reset request level written by the host
);
   // Each action code below 8 decodes to a single-cycle pulse, as a bus decoder would give
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ev_o <= 8'h00;
      end else begin
         ev_o <= (go_i && op_i < 4'h8) ? 8'h01 << op_i : 8'h00;
      end
   end
   // Full beside a full write, empty beside a plain write; toggles otherwise so a stale level is never trusted
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         fifo_full_o <= 1'b0;
      end else if (go_i && op_i == 4'h4) begin
         fifo_full_o <= 1'b1;
      end else if (go_i && op_i == 4'h1) begin
         fifo_full_o <= 1'b0;
      end else begin
         fifo_full_o <= ~fifo_full_o;
      end
   end
   // Host raises or drops the reset request bit
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rst_req_o <= 1'b0;
      end else if (go_i && op_i == 4'h8) begin
         rst_req_o <= 1'b1;
      end else if (go_i && op_i == 4'h9) begin
         rst_req_o <= 1'b0;
      end
   end
endmodule : btirq_host_model
`default_nettype wire

/* File: dv/btirq_monitor.sv */
// Checker: port assertions of the transfer interrupt block
`timescale 1ns/10ps
`default_nettype none
module btirq_monitor
   import btirq_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic [ADDR_W-1:0] awaddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic [1:0] bresp_o,
   input wire logic bvalid_o,
   input wire logic host_byte_read_i,
   input wire logic host_byte_write_i,
   input wire logic host_write_start_i,
   input wire logic host_read_end_i,
   input wire logic fifo_full_i,
   input wire logic status_code_rx_end_i,
   input wire logic control_code_tx_end_i,
   input wire logic transfer_start_i,
   input wire logic slave_hw_reset_request_i,
   input wire logic shared_slave_interrupt_o
);
   logic [7:0] sh_reg [8]; // Shadow of committed bytes, by word
   logic [2:0] ai_reg; // Word of the write in flight
   logic [7:0] wd_reg; // Byte of the write in flight
   logic ws_reg; // Lane 0 strobe of the write in flight
   logic bv_reg; // Response valid one cycle ago
   logic glob; // Shadowed global enable
   logic ev_any; // Any event input
   logic commit; // Write answered this cycle; the block already holds it
   logic [7:0] cur [8]; // Register view as the block holds it this cycle
   assign commit = bvalid_o && !bv_reg && bresp_o == RESP_OKAY && ws_reg;
   // The shadow lags the block by one edge, so a fresh commit is folded in here
   always_comb begin
      cur = sh_reg;
      if (commit) begin
         cur[ai_reg] = wd_reg;
      end
   end
   assign glob = cur[5][BIT_GLOBAL_EN];
   assign ev_any = host_byte_read_i | host_byte_write_i | host_write_start_i
      | host_read_end_i | status_code_rx_end_i | control_code_tx_end_i
      | transfer_start_i | slave_hw_reset_request_i;
   // Follow committed writes so gates are known; refused ones change nothing
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sh_reg <= '{default: 8'h00};
         ai_reg <= 3'h0;
         wd_reg <= 8'h00;
         ws_reg <= 1'b0;
         bv_reg <= 1'b0;
      end else begin
         bv_reg <= bvalid_o;
         if (awvalid_i && awready_o) ai_reg <= awaddr_i[4:2];
         if (wvalid_i && wready_o) wd_reg <= wdata_i[7:0];
         if (wvalid_i && wready_o) ws_reg <= wstrb_i[0];
         if (commit) sh_reg[ai_reg] <= wd_reg;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // An enabled event under the global gate
   sequence s_arm(ev, en);
      glob && en && ev;
   endsequence
   // Set one edge later raises the line, unless a write just changed things
   property p_set(ev, en);
      s_arm(ev, en) |=> shared_slave_interrupt_o || $rose(bvalid_o);
   endproperty
   AST_HOST_READ: assert property (p_set(host_byte_read_i, cur[3][BIT_HOST_RD]))
      else $error("no irq after host read");
   AST_HOST_WRITE: assert property (p_set(host_byte_write_i, cur[3][BIT_HOST_WR]))
      else $error("no irq after host write");
   AST_FIFO_REQ: assert property (p_set(host_byte_write_i && fifo_full_i, cur[3][BIT_FIFO_RD_REQ]))
      else $error("no irq after full write");
   AST_SRC_STS: assert property (p_set(status_code_rx_end_i, cur[0][BIT_STS_RX_END]))
      else $error("no irq after status end");
   AST_SLV_RST: assert property (s_arm($rose(slave_hw_reset_request_i), cur[4][BIT_SLV_RST])
      |-> ##[1:2] (shared_slave_interrupt_o || $rose(bvalid_o))) else $error("no reset irq");
   AST_GLOBAL_GATE: assert property (!glob |-> !shared_slave_interrupt_o)
      else $error("irq while globally off");
   AST_IRQ_RISE: assert property ($rose(shared_slave_interrupt_o)
      |-> $past(ev_any) || $rose(bvalid_o)) else $error("irq rose without cause");
   AST_IRQ_FALL: assert property ($fell(shared_slave_interrupt_o) |-> $rose(bvalid_o))
      else $error("irq fell without a write");
endmodule : btirq_monitor
bind btirq_top btirq_monitor u_mon (.clk_i, .rst_b_i, .awvalid_i, .awready_o, .awaddr_i,
   .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .host_byte_read_i,
   .host_byte_write_i, .host_write_start_i, .host_read_end_i, .fifo_full_i,
   .status_code_rx_end_i, .control_code_tx_end_i, .transfer_start_i,
   .slave_hw_reset_request_i, .shared_slave_interrupt_o);
`default_nettype wire

/* File: dv/block_transfer_slave_irq_flags_bench.sv */
// Bench: random and corner checks of the transfer interrupt block
`timescale 1ns/10ps
`default_nettype none
module block_transfer_slave_irq_flags_bench
   import btirq_pkg::*;
;
   logic clk_i, rst_b_i, awvalid_i, wvalid_i, arvalid_i, go; // Clock, reset, requests
   logic [ADDR_W-1:0] awaddr_i, araddr_i; // Bus addresses
   logic [31:0] wdata_i, rdata_o; // Bus data
   logic [3:0] wstrb_i, op; // Lane strobes and host action
   logic [1:0] bresp_o, rresp_o; // Bus responses
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o; // Bus answers
   logic shared_slave_interrupt_o, fifo_full, rst_req; // Interrupt and host levels
   logic [7:0] ev; // Host event pulses
   logic [7:0] en; // Enables under test
   logic g; // Global enable under test
   int fail_count = 0;
   int compares = 0;
   int n, p, o; // Loop counters
   int seed = 22; // Fixed seed keeps runs repeatable
   // Responses are always accepted at once, which keeps each wait short
   btirq_top dut (.clk_i, .rst_b_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
      .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i(1'b1), .araddr_i, .arvalid_i,
      .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i(1'b1), .host_byte_read_i(ev[0]),
      .host_byte_write_i(ev[1] | ev[4]), .host_write_start_i(ev[2]),
      .host_read_end_i(ev[3]), .fifo_full_i(fifo_full), .status_code_rx_end_i(ev[5]),
      .control_code_tx_end_i(ev[6]), .transfer_start_i(ev[7]),
      .slave_hw_reset_request_i(rst_req), .shared_slave_interrupt_o);
   btirq_host_model host (.clk_i, .rst_b_i, .go_i(go), .op_i(op), .ev_o(ev),
      .fifo_full_o(fifo_full), .rst_req_o(rst_req));
   // Free-running system clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Counts, verdict and end of run
   task automatic close_out();
      $display("fail_count=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // Value comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Interrupt line comparison
   task automatic chk_irq(input logic exp);
      chk({31'h0, shared_slave_interrupt_o}, {31'h0, exp});
   endtask : chk_irq
   // Bus write: both halves offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      awaddr_i <= a;
      wdata_i <= d;
      wstrb_i <= s;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (awready_o) awvalid_i <= 1'b0;
         if (wready_o) wvalid_i <= 1'b0;
         if (bvalid_o) break;
      end
      if (n == 40) begin
         fail_count++;
         close_out();
      end
      chk({30'h0, bresp_o}, {30'h0, er});
   endtask : wr
   // Bus read with data and response compared
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (arready_o && arvalid_i) arvalid_i <= 1'b0;
         if (rvalid_o) break;
      end
      if (n == 40) begin
         fail_count++;
         close_out();
      end
      chk(rdata_o, e);
      chk({30'h0, rresp_o}, {30'h0, er});
   endtask : rd
   // One host action, then time for the flag to land
   task automatic fire(input logic [3:0] c);
      op <= c;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : fire
   // Flag bits that an action sets
   function automatic logic [7:0] fmask(input int c);
      return c < 4 ? 8'h08 >> c : c == 4 ? 8'h14 : c < 8 ? 8'h04 >> (c - 5) : 8'h40;
   endfunction : fmask
   // Status or enable word of an action
   function automatic logic [7:0] faddr(input int c, input bit e);
      if (c < 5) return e ? OFF_EN_LO : OFF_STAT_LO;
      if (c < 8) return e ? OFF_SRC_EN : OFF_SRC_FLAG;
      return e ? OFF_EN_HI : OFF_STAT_HI;
   endfunction : faddr
   // Main sequence
   initial begin
      {rst_b_i, awvalid_i, wvalid_i, arvalid_i, go} = 5'h00;
      {awaddr_i, araddr_i, wdata_i, wstrb_i, op} = 56'h0;
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      for (o = 0; o < 7; o++) rd(8'(o * 4), 32'h0, RESP_OKAY);
      wr(OFF_STAT_LO, 32'hFF, 4'hF, RESP_OKAY);
      rd(OFF_STAT_LO, 32'hE0, RESP_OKAY);
      wr(OFF_STAT_LO, 32'h00, 4'hF, RESP_OKAY);
      wr(8'h1C, 32'hFF, 4'hF, RESP_SLVERR);
      rd(8'h1C, 32'h0, RESP_SLVERR);
      wr(OFF_EN_LO, 32'h1F, 4'hE, RESP_OKAY);
      rd(OFF_EN_LO, 32'h0, RESP_OKAY);
      // All enabled, globally off, then random enables, for every action
      for (p = 0; p < 3; p++) begin
         for (o = 0; o < 9; o++) begin
            en = p < 2 ? 8'hFF : 8'($random(seed));
            g = p == 0 ? 1'b1 : p == 1 ? 1'b0 : 1'($random(seed));
            wr(faddr(o, 1), {24'h0, en}, 4'h1, RESP_OKAY);
            wr(OFF_HOST_CTRL, {31'h0, g}, 4'h1, RESP_OKAY);
            if (o == 8) fire(4'h9);
            fire(4'(o));
            wr(faddr(o, 0), 32'h0, 4'h1, RESP_OKAY);
            chk_irq(g & (|(en & fmask(o))));
            rd(faddr(o, 0), {24'h0, fmask(o)}, RESP_OKAY);
            wr(faddr(o, 0), {24'h0, fmask(o)}, 4'h1, RESP_OKAY);
            rd(faddr(o, 0), {24'h0, fmask(o)}, RESP_OKAY);
            wr(faddr(o, 0), 32'h0, 4'h1, RESP_OKAY); // FIFO assumed drained
            chk_irq(1'b0);
            rd(faddr(o, 0), 32'h0, RESP_OKAY);
         end
      end
      close_out();
   end
endmodule : block_transfer_slave_irq_flags_bench
`default_nettype wire
